// ### pcs_pkg.sv
`default_nettype none
package pcs_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADR_CS1_BASE = 8'h00;
  localparam logic [7:0] ADR_CS2_BASE = 8'h04;
  localparam logic [7:0] ADR_CS1_MODE = 8'h08;
  localparam logic [7:0] ADR_CS2_MODE = 8'h0C;
  localparam logic [7:0] ADR_STATUS   = 8'h10;
  localparam logic [7:0] ADR_PAD_CFG  = 8'h14;
  localparam logic [7:0] ADR_CONTROL  = 8'h18;
  localparam logic [7:0] ADR_MST_STAT = 8'h1C;
  localparam logic [7:0] ADR_IN_WORD0 = 8'h20;
  localparam logic [7:0] ADR_IN_WORD1 = 8'h24;
  localparam logic [7:0] ADR_OUT_WORD0 = 8'h28;
  localparam logic [7:0] ADR_OUT_WORD1 = 8'h2C;
  localparam logic [7:0] ADR_MST_ADRL = 8'h30;
  localparam logic [7:0] ADR_MST_ADRH = 8'h34;
  localparam logic [7:0] ADR_MST_DATA = 8'h38;
  localparam logic [7:0] ADR_MST_CMD  = 8'h3C;

  // ****************************************************************
  // Reset values and field layout
  // ****************************************************************
  localparam logic [15:0] RST_CS1_BASE = 16'h0200;
  localparam logic [15:0] RST_CS2_BASE = 16'h0600;
  localparam logic [15:0] BASE_MASK    = 16'hFF88;
  localparam logic [15:0] MODE_MASK    = 16'hF8FF;
  localparam logic [3:0]  RST_OB_EMPTY = 4'hF;
  localparam logic [12:0] RST_HOST_SYNC = 13'h1C00;
  localparam int ACK_HANDLING_MODE_POS   = 14;
  localparam int ALT_MASTER_WAIT_STATES_POS = 11;
  localparam int DWB_POS    = 6;
  localparam int DWM_POS    = 2;
  localparam int DWE_POS    = 0;
  localparam int CTL_SLAVE  = 0;
  localparam int CTL_CALOE  = 1;
  localparam int CTL_ALTM   = 2;
  localparam int PAD_TTL    = 0;
  localparam int PAD_SECSEL = 1;
  localparam int CMD_READ   = 0;
  localparam int CMD_START  = 1;

  localparam logic [1:0] ACK_NONE    = 2'h0;
  localparam logic [1:0] ACK_TIMEOUT = 2'h1;
  localparam logic [1:0] ACK_WAIT    = 2'h2;

  // ****************************************************************
  // Timing: the access engine counts quarter instruction cycles
  // ****************************************************************
  localparam int CLK_NS      = 8;
  localparam int TCY_NS      = 32;
  localparam int QTR_CLKS    = (TCY_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int QTR_PER_TCY = 4;
  localparam int AMW_OFFSET  = 3;
  localparam int ACK_MAX_TCY = 255;

  typedef enum logic [2:0] {
    PCS_IDLE   = 3'b000,
    PCS_ALTW   = 3'b001,
    PCS_SETUP  = 3'b010,
    PCS_STROBE = 3'b011,
    PCS_HOLD   = 3'b100
  } pcs_state_t;

endpackage : pcs_pkg
`default_nettype wire

// ### pcs_buf_mem.sv
`timescale 1ns/100ps
`default_nettype none
module pcs_buf_mem #(
  parameter int AW = 1
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic          wr_en,
  input  wire logic [1:0]    wr_be,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [15:0]   wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [15:0]   rd_data_q
);

  logic [15:0] mem_q [2**AW];

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (wr_en) begin
      if (wr_be[0]) begin
        mem_q[wr_addr][7:0] <= wr_data[7:0];
      end
      if (wr_be[1]) begin
        mem_q[wr_addr][15:8] <= wr_data[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule : pcs_buf_mem
`default_nettype wire

// ### pcs_top.sv
`timescale 1ns/100ps
`default_nettype none
module pcs_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        host_cs_b,
  input  wire logic        host_rd_b,
  input  wire logic        host_wr_b,
  input  wire logic [1:0]  host_addr,
  input  wire logic [7:0]  host_d_in,
  output logic      [7:0]  host_d_out,
  output logic             host_d_oe_b,
  input  wire logic        external_acknowledge_input,
  input  wire logic [15:0] pm_d_in,
  output logic      [15:0] pm_d_out,
  output logic             pm_d_oe_b,
  output logic      [23:0] pm_addr,
  output logic             pm_cs1,
  output logic             pm_cs2,
  output logic             pm_rd_strobe,
  output logic             pm_wr_strobe,
  input  wire logic        cal_seconds_clk,
  input  wire logic        cal_alarm_pulse,
  output logic             cal_pin_out,
  output logic             cal_pin_oe_b,
  output logic             input_threshold_select
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [15:0] cs1_base_q, cs2_base_q, cs1_mode_q, cs2_mode_q;
  logic [1:0]  pad_q;
  logic [2:0]  ctrl_q;
  logic [23:0] madr_q;
  logic [15:0] mdata_q;
  logic        timeout_q;
  logic        wr_hit;

  assign wr_hit = reg_wr;

  function automatic logic [23:0] base_of(input logic [15:0] r);
    base_of = {r[15:7], 3'b000, r[3], 11'h000};
  endfunction : base_of

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cs1_base_q <= pcs_pkg::RST_CS1_BASE;
      cs2_base_q <= pcs_pkg::RST_CS2_BASE;
    end else if (wr_hit && reg_addr == pcs_pkg::ADR_CS1_BASE) begin
      cs1_base_q <= reg_wdata & pcs_pkg::BASE_MASK;
    end else if (wr_hit && reg_addr == pcs_pkg::ADR_CS2_BASE) begin
      cs2_base_q <= reg_wdata & pcs_pkg::BASE_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cs1_mode_q <= 16'h0000;
      cs2_mode_q <= 16'h0000;
      pad_q      <= 2'h0;
      ctrl_q     <= 3'h0;
    end else if (wr_hit) begin
      case (reg_addr)
        pcs_pkg::ADR_CS1_MODE: cs1_mode_q <= reg_wdata & pcs_pkg::MODE_MASK;
        pcs_pkg::ADR_CS2_MODE: cs2_mode_q <= reg_wdata & pcs_pkg::MODE_MASK;
        pcs_pkg::ADR_PAD_CFG:  pad_q <= reg_wdata[1:0];
        pcs_pkg::ADR_CONTROL:  ctrl_q <= reg_wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  logic slave_mode;
  assign slave_mode = ctrl_q[pcs_pkg::CTL_SLAVE];
  assign input_threshold_select = pad_q[pcs_pkg::PAD_TTL];

  // ****************************************************************
  // Calendar pin
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cal_pin_out  <= 1'b0;
      cal_pin_oe_b <= 1'b1;
    end else begin
      cal_pin_out  <= pad_q[pcs_pkg::PAD_SECSEL] ? cal_seconds_clk
                                                  : cal_alarm_pulse;
      cal_pin_oe_b <= ~ctrl_q[pcs_pkg::CTL_CALOE];
    end
  end

  // ****************************************************************
  // Host pin synchronisers
  // ****************************************************************
  logic [12:0] hs1_q, hs2_q;
  logic        hwr_prev_q, hrd_prev_q;
  logic        h_wr, h_rd, h_wr_ev, h_rd_ev;
  logic [1:0]  h_adr;
  logic [7:0]  h_din;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hs1_q      <= pcs_pkg::RST_HOST_SYNC;
      hs2_q      <= pcs_pkg::RST_HOST_SYNC;
      hwr_prev_q <= 1'b0;
      hrd_prev_q <= 1'b0;
    end else begin
      // Raw pins are flopped twice before any gate sees them, so no glitch is sampled.
      hs1_q      <= {host_cs_b, host_wr_b, host_rd_b, host_addr, host_d_in};
      hs2_q      <= hs1_q;
      hwr_prev_q <= h_wr;
      hrd_prev_q <= h_rd;
    end
  end

  assign h_wr    = ~hs2_q[12] & ~hs2_q[11];
  assign h_rd    = ~hs2_q[12] & ~hs2_q[10];
  assign h_adr   = hs2_q[9:8];
  assign h_din   = hs2_q[7:0];
  assign h_wr_ev = h_wr & ~hwr_prev_q & slave_mode;
  assign h_rd_ev = h_rd & ~hrd_prev_q & slave_mode;

  // ****************************************************************
  // Slave buffers and their flags
  // ****************************************************************
  logic [3:0]  ib_full_q, ob_empty_q;
  logic [3:0]  ib_set, ib_clr, ob_set, ob_clr;
  logic        input_overflow_q, output_underflow_q;
  logic        loc_rd_in, loc_wr_out;
  logic [15:0] in_rdata, out_rdata;
  logic        hsel_q;
  logic        hrd_pend_q;

  function automatic logic [3:0] word_bits(input logic w);
    word_bits = w ? 4'hC : 4'h3;
  endfunction : word_bits

  assign loc_rd_in = reg_rd && (reg_addr == pcs_pkg::ADR_IN_WORD0 ||
                                reg_addr == pcs_pkg::ADR_IN_WORD1);
  assign loc_wr_out = wr_hit && (reg_addr == pcs_pkg::ADR_OUT_WORD0 ||
                                 reg_addr == pcs_pkg::ADR_OUT_WORD1);

  always_comb begin
    ib_set = 4'h0;
    ib_clr = 4'h0;
    ob_set = 4'h0;
    ob_clr = 4'h0;
    if (slave_mode) begin
      if (h_wr_ev) begin
        ib_set = 4'h1 << h_adr;
      end
      if (h_rd_ev) begin
        ob_set = word_bits(h_adr[1]);
      end
      if (loc_rd_in) begin
        ib_clr = word_bits(reg_addr[2]);
      end
      if (loc_wr_out) begin
        ob_clr = word_bits(reg_addr[2]);
      end
    end
  end

  // A flag set by the host wins over a clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ib_full_q  <= 4'h0;
      ob_empty_q <= pcs_pkg::RST_OB_EMPTY;
    end else begin
      ib_full_q  <= (ib_full_q & ~ib_clr) | ib_set;
      ob_empty_q <= (ob_empty_q & ~ob_clr) | ob_set;
    end
  end

  // Overflow and underflow clear when software writes a zero to them.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      input_overflow_q <= 1'b0;
      output_underflow_q <= 1'b0;
    end else begin
      input_overflow_q <= (wr_hit && reg_addr == pcs_pkg::ADR_STATUS ? reg_wdata[14] : input_overflow_q)
                | (h_wr_ev & ib_full_q[h_adr]);
      output_underflow_q <= (wr_hit && reg_addr == pcs_pkg::ADR_STATUS ? reg_wdata[6] : output_underflow_q)
                | (h_rd_ev & ob_empty_q[h_adr]);
    end
  end

  pcs_buf_mem #(.AW(1)) u_in_buf (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .wr_en     (h_wr_ev),
    .wr_be     (h_adr[0] ? 2'b10 : 2'b01),
    .wr_addr   (h_adr[1]),
    .wr_data   ({h_din, h_din}),
    .rd_addr   (reg_addr[2]),
    .rd_data_q (in_rdata)
  );

  pcs_buf_mem #(.AW(1)) u_out_buf (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .wr_en     (loc_wr_out & slave_mode),
    .wr_be     (2'b11),
    .wr_addr   (reg_addr[2]),
    .wr_data   (reg_wdata),
    .rd_addr   (h_adr[1]),
    .rd_data_q (out_rdata)
  );

  // Host read data reach the pins two cycles after the synchronised strobe.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hsel_q      <= 1'b0;
      hrd_pend_q  <= 1'b0;
      host_d_out  <= 8'h00;
      host_d_oe_b <= 1'b1;
    end else begin
      hsel_q     <= h_adr[0];
      hrd_pend_q <= h_rd_ev;
      if (hrd_pend_q) begin
        host_d_out <= hsel_q ? out_rdata[15:8] : out_rdata[7:0];
      end
      host_d_oe_b <= ~(h_rd & slave_mode);
    end
  end

  // ****************************************************************
  // Master access engine
  // ****************************************************************
  pcs_pkg::pcs_state_t state_q;
  logic [10:0] cnt_q, ack_cnt_q;
  logic        is_read_q, sel_cs2_q, ack_s1_q, ack_s2_q;
  logic [15:0] pd_s1_q, pd_s2_q, mode;
  logic [1:0]  ack_handling_mode;
  logic [3:0]  dwm;
  logic        start, cs2_hit, cs1_hit, cs2_zero;
  logic [10:0] setup_len, strobe_len, hold_len, altw_len, ack_limit;

  assign start = wr_hit && reg_addr == pcs_pkg::ADR_MST_CMD &&
                 reg_wdata[pcs_pkg::CMD_START] && !slave_mode &&
                 state_q == pcs_pkg::PCS_IDLE;

  assign cs2_zero = (cs2_base_q == 16'h0000);
  assign cs2_hit  = !cs2_zero && madr_q >= base_of(cs2_base_q);
  assign cs1_hit  = !cs2_hit && madr_q >= base_of(cs1_base_q);

  assign mode = sel_cs2_q ? cs2_mode_q : cs1_mode_q;
  assign ack_handling_mode = mode[pcs_pkg::ACK_HANDLING_MODE_POS +: 2];
  assign dwm  = mode[pcs_pkg::DWM_POS +: 4];

  always_comb begin
    altw_len  = 11'((32'(mode[pcs_pkg::ALT_MASTER_WAIT_STATES_POS +: 3]) + pcs_pkg::AMW_OFFSET)
                    * pcs_pkg::QTR_PER_TCY * pcs_pkg::QTR_CLKS);
    setup_len = 11'((32'(mode[pcs_pkg::DWB_POS +: 2]) * pcs_pkg::QTR_PER_TCY + 1)
                    * pcs_pkg::QTR_CLKS);
    strobe_len = 11'((32'(dwm) * pcs_pkg::QTR_PER_TCY + (is_read_q ? 3 : 2))
                     * pcs_pkg::QTR_CLKS);
    hold_len  = 11'((32'(mode[pcs_pkg::DWE_POS +: 2]) * pcs_pkg::QTR_PER_TCY
                     + (is_read_q ? 0 : 1)) * pcs_pkg::QTR_CLKS);
    ack_limit = 11'((dwm == 4'h0 ? pcs_pkg::ACK_MAX_TCY : 32'(dwm))
                    * pcs_pkg::QTR_PER_TCY * pcs_pkg::QTR_CLKS);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      pd_s1_q  <= 16'h0000;
      pd_s2_q  <= 16'h0000;
    end else begin
      ack_s1_q <= external_acknowledge_input;
      ack_s2_q <= ack_s1_q;
      pd_s1_q  <= pm_d_in;
      pd_s2_q  <= pd_s1_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      madr_q <= 24'h000000;
    end else if (wr_hit && reg_addr == pcs_pkg::ADR_MST_ADRL) begin
      madr_q[15:0] <= reg_wdata;
    end else if (wr_hit && reg_addr == pcs_pkg::ADR_MST_ADRH) begin
      madr_q[23:16] <= reg_wdata[7:0];
    end
  end

  logic strobe_done, ack_abort;
  assign strobe_done = (cnt_q + 11'h001 >= strobe_len) &&
                       (ack_handling_mode == pcs_pkg::ACK_NONE || ack_handling_mode == 2'h3 ||
                        ack_s2_q);
  assign ack_abort = ack_handling_mode == pcs_pkg::ACK_TIMEOUT &&
                     ack_cnt_q + 11'h001 >= ack_limit && !ack_s2_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q   <= pcs_pkg::PCS_IDLE;
      cnt_q     <= 11'h000;
      ack_cnt_q <= 11'h000;
      is_read_q <= 1'b0;
      sel_cs2_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 11'h001;
      case (state_q)
        pcs_pkg::PCS_IDLE: begin
          cnt_q <= 11'h000;
          if (start) begin
            is_read_q <= reg_wdata[pcs_pkg::CMD_READ];
            sel_cs2_q <= cs2_hit;
            state_q   <= ctrl_q[pcs_pkg::CTL_ALTM] ? pcs_pkg::PCS_ALTW
                                                   : pcs_pkg::PCS_SETUP;
          end
        end
        pcs_pkg::PCS_ALTW: begin
          if (cnt_q + 11'h001 >= altw_len) begin
            cnt_q   <= 11'h000;
            state_q <= pcs_pkg::PCS_SETUP;
          end
        end
        pcs_pkg::PCS_SETUP: begin
          ack_cnt_q <= 11'h000;
          if (cnt_q + 11'h001 >= setup_len) begin
            cnt_q   <= 11'h000;
            state_q <= pcs_pkg::PCS_STROBE;
          end
        end
        pcs_pkg::PCS_STROBE: begin
          ack_cnt_q <= ack_cnt_q + 11'h001;
          if (strobe_done || ack_abort) begin
            cnt_q   <= 11'h000;
            state_q <= (hold_len == 11'h000) ? pcs_pkg::PCS_IDLE
                                             : pcs_pkg::PCS_HOLD;
          end else if (cnt_q + 11'h001 >= strobe_len) begin
            cnt_q <= cnt_q; // Strobe held while the acknowledge is awaited.
          end
        end
        pcs_pkg::PCS_HOLD: begin
          if (cnt_q + 11'h001 >= hold_len) begin
            state_q <= pcs_pkg::PCS_IDLE;
          end
        end
        default: state_q <= pcs_pkg::PCS_IDLE;
      endcase
    end
  end

  // Sticky time-out; software clears it by writing one, a new event wins.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= (timeout_q & ~(wr_hit && reg_addr == pcs_pkg::ADR_MST_STAT
                                  && reg_wdata[0]))
                   | (state_q == pcs_pkg::PCS_STROBE && ack_abort);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mdata_q <= 16'h0000;
    end else if (state_q == pcs_pkg::PCS_STROBE && is_read_q
                 && (strobe_done || ack_abort)) begin
      mdata_q <= pd_s2_q;
    end else if (wr_hit && reg_addr == pcs_pkg::ADR_MST_DATA) begin
      mdata_q <= reg_wdata;
    end
  end

  logic active;
  assign active = state_q != pcs_pkg::PCS_IDLE;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pm_addr      <= 24'h000000;
      pm_d_out     <= 16'h0000;
      pm_d_oe_b    <= 1'b1;
      pm_cs1       <= 1'b0;
      pm_cs2       <= 1'b0;
      pm_rd_strobe <= 1'b0;
      pm_wr_strobe <= 1'b0;
    end else begin
      pm_addr      <= madr_q;
      pm_d_out     <= mdata_q;
      pm_d_oe_b    <= ~(active && state_q != pcs_pkg::PCS_ALTW && !is_read_q);
      pm_cs1       <= active && !sel_cs2_q && cs1_hit;
      pm_cs2       <= active && sel_cs2_q;
      pm_rd_strobe <= state_q == pcs_pkg::PCS_STROBE && is_read_q;
      pm_wr_strobe <= state_q == pcs_pkg::PCS_STROBE && !is_read_q;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  logic [15:0] rd_q;
  logic        rd_mem_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_q     <= 16'h0000;
      rd_mem_q <= 1'b0;
    end else begin
      rd_mem_q <= loc_rd_in;
      rd_q     <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          pcs_pkg::ADR_CS1_BASE: rd_q <= cs1_base_q;
          pcs_pkg::ADR_CS2_BASE: rd_q <= cs2_base_q;
          pcs_pkg::ADR_CS1_MODE: rd_q <= cs1_mode_q;
          pcs_pkg::ADR_CS2_MODE: rd_q <= cs2_mode_q;
          pcs_pkg::ADR_STATUS: rd_q <= {&ib_full_q, input_overflow_q, 2'b00, ib_full_q,
                                        &ob_empty_q, output_underflow_q, 2'b00,
                                        ob_empty_q};
          pcs_pkg::ADR_PAD_CFG:  rd_q <= {14'h0000, pad_q};
          pcs_pkg::ADR_CONTROL:  rd_q <= {13'h0000, ctrl_q};
          pcs_pkg::ADR_MST_STAT: rd_q <= {active, 14'h0000, timeout_q};
          pcs_pkg::ADR_MST_ADRL: rd_q <= madr_q[15:0];
          pcs_pkg::ADR_MST_ADRH: rd_q <= {8'h00, madr_q[23:16]};
          pcs_pkg::ADR_MST_DATA: rd_q <= mdata_q;
          default:               rd_q <= 16'h0000;
        endcase
      end
    end
  end

  assign reg_rdata = rd_mem_q ? in_rdata : rd_q;

endmodule : pcs_top
`default_nettype wire

// ### pcs_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ********************************
// Port timing checks
// ********************************
module pcs_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic host_cs_b,
  input wire logic host_rd_b,
  input wire logic host_d_oe_b,
  input wire logic pm_d_oe_b,
  input wire logic pm_cs1,
  input wire logic pm_cs2,
  input wire logic pm_rd_strobe,
  input wire logic pm_wr_strobe,
  input wire logic cal_pin_oe_b
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  chk_strobe_excl: assert property (!(pm_rd_strobe && pm_wr_strobe))
    else $error("both strobes active");
  chk_cs_excl: assert property (!(pm_cs1 && pm_cs2))
    else $error("both chip selects active");
  chk_wr_min: assert property ($rose(pm_wr_strobe) |-> pm_wr_strobe[*2])
    else $error("write strobe too short");
  chk_rd_min: assert property ($rose(pm_rd_strobe) |-> pm_rd_strobe[*3])
    else $error("read strobe too short");
  chk_wr_setup: assert property ($rose(pm_wr_strobe) |-> $past(!pm_d_oe_b && (pm_cs1 || pm_cs2)))
    else $error("write data not set up before strobe");
  chk_wr_hold: assert property ($fell(pm_wr_strobe) |-> !pm_d_oe_b && (pm_cs1 || pm_cs2))
    else $error("write data not held after strobe");
  chk_rd_float: assert property (pm_rd_strobe |-> pm_d_oe_b)
    else $error("data driven during read strobe");
  // The host pins pass two synchroniser flops and one output flop.
  chk_host_oe: assert property (!host_d_oe_b |-> $past(!host_cs_b && !host_rd_b, 3))
    else $error("host data driven without host read");
  chk_reset_idle: assert property (disable iff (1'b0) !rst_b |=> pm_d_oe_b && host_d_oe_b && cal_pin_oe_b)
    else $error("outputs not idle in reset");
endmodule : pcs_chk
bind pcs_top pcs_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .host_cs_b(host_cs_b),
  .host_rd_b(host_rd_b), .host_d_oe_b(host_d_oe_b), .pm_d_oe_b(pm_d_oe_b), .pm_cs1(pm_cs1),
  .pm_cs2(pm_cs2), .pm_rd_strobe(pm_rd_strobe), .pm_wr_strobe(pm_wr_strobe),
  .cal_pin_oe_b(cal_pin_oe_b));
`default_nettype wire

// ### pcs_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********************************
// External memory with a slow acknowledge
// ********************************
module pcs_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        pm_rd_strobe,
  input  wire logic        pm_wr_strobe,
  input  wire logic [23:0] pm_addr,
  input  wire logic        ack_en,
  input  wire logic [7:0]  ack_dly,
  output logic             external_acknowledge_input,
  output logic      [15:0] pm_d_in
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    external_acknowledge_input = 1'h0;
    pm_d_in = 16'h0000;
  end
  // Released data toggles so a late capture never sees a stale match.
  always @(posedge ref_clk) begin
    cnt <= (pm_rd_strobe || pm_wr_strobe) && cnt != 8'hFF ? cnt + 8'h01 : 8'h00;
    external_acknowledge_input <= ack_en && (pm_rd_strobe || pm_wr_strobe) && cnt >= ack_dly;
    pm_d_in <= pm_rd_strobe ? {pm_addr[7:0], 8'h5A} : ~pm_d_in;
  end
endmodule : pcs_mem_model
`default_nettype wire

// ### test_parallel_port_cs_timing_status.sv
`timescale 1ns/100ps
`default_nettype none
module test_parallel_port_cs_timing_status;
  logic        ref_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, ack_en = 1'h1;
  logic        host_cs_b = 1'h1, host_rd_b = 1'h1, host_wr_b = 1'h1;
  logic        cal_seconds_clk = 1'h0, cal_alarm_pulse = 1'h0, external_acknowledge_input;
  logic        host_d_oe_b, pm_d_oe_b, pm_cs1, pm_cs2, pm_rd_strobe, pm_wr_strobe;
  logic        cal_pin_out, cal_pin_oe_b, input_threshold_select;
  logic [1:0]  host_addr = 2'h0, cs_hit;
  logic [7:0]  reg_addr = 8'h00, host_d_in = 8'h00, ack_dly = 8'h00, host_d_out;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, pm_d_in, pm_d_out, pd;
  logic [23:0] pm_addr;
  logic [16:0] tbl [4] = '{17'h00000, 17'h000FF, 17'h0C000, 17'h10045};
  int          fails = 0, num_checks = 0, cyc = 0, su, sl, tt, t0, tb0;

  pcs_top DUT (.*);
  pcs_mem_model u_mem (.*);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      end_of_test;
    end
  end

  // ********************************
  // Access tasks
  // ********************************
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task rdc(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    cmp(n, e, reg_rdata);
  endtask : rdc
  // Host strobes stay long enough to pass the two-flop synchroniser.
  task hst(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    host_d_in <= d;
    host_cs_b <= 1'h0;
    host_wr_b <= !w;
    host_rd_b <= w;
    repeat (5) @(posedge ref_clk);
    {host_cs_b, host_wr_b, host_rd_b} <= 3'h7;
    repeat (5) @(posedge ref_clk);
    host_d_in <= ~d;
  endtask : hst
  task acc(input logic r, input logic [15:0] m);
    wr(pcs_pkg::ADR_CS1_MODE, m);
    wr(pcs_pkg::ADR_MST_CMD, {14'h0, 1'h1, r});
    #1;
    t0 = cyc;
    su = 0;
    sl = 0;
    while (!(pm_cs1 || pm_cs2) && cyc < t0 + 500) tick;
    cs_hit = {pm_cs2, pm_cs1};
    while (!(pm_rd_strobe || pm_wr_strobe) && cyc < t0 + 500) begin
      su++;
      tick;
    end
    tt = cyc - t0;
    pd = pm_d_out;
    while ((pm_rd_strobe || pm_wr_strobe) && cyc < t0 + 1500) begin
      sl++;
      tick;
    end
    while ((pm_cs1 || pm_cs2) && cyc < t0 + 1500) tick;
    tick;
  endtask : acc

  // ********************************
  // Tests
  // ********************************
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'h1;
    rdc("cs1 base", pcs_pkg::ADR_CS1_BASE, 16'h0200);
    rdc("cs2 base", pcs_pkg::ADR_CS2_BASE, 16'h0600);
    rdc("status", pcs_pkg::ADR_STATUS, 16'h008F);
    rdc("unmapped", 8'hFC, 16'h0000);
    wr(pcs_pkg::ADR_CS1_BASE, 16'hFFFF);
    rdc("cs1 mask", pcs_pkg::ADR_CS1_BASE, 16'hFF88);
    wr(pcs_pkg::ADR_CS1_BASE, 16'h0200);
    wr(pcs_pkg::ADR_MST_ADRH, 16'h0002);
    wr(pcs_pkg::ADR_MST_ADRL, 16'h0012);
    wr(pcs_pkg::ADR_MST_DATA, 16'hA5C3);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      acc(tbl[i][16], tbl[i][15:0]);
      if (i == 0) tb0 = tt;
      cmp("setup", 16'(tbl[i][7:6] * 4 + 1), 16'(su));
      cmp("strobe", 16'(tbl[i][5:2] * 4 + 2 + tbl[i][16]), 16'(sl));
      if (!tbl[i][16]) cmp("write data", 16'hA5C3, pd);
    end
    rdc("read data", pcs_pkg::ADR_MST_DATA, 16'h125A);
    wr(pcs_pkg::ADR_CONTROL, 16'h0004);
    acc(1'h0, 16'h3800);
    cmp("alt wait", 16'(tb0 + 40), 16'(tt));
    wr(pcs_pkg::ADR_CONTROL, 16'h0000);
    ack_dly = 8'h1E;
    acc(1'h0, 16'h8000);
    cmp("ack wait", 16'(sl >= 30), 16'h0001);
    rdc("no timeout", pcs_pkg::ADR_MST_STAT, 16'h0000);
    ack_en = 1'h0;
    acc(1'h0, 16'h4008);
    rdc("timeout", pcs_pkg::ADR_MST_STAT, 16'h0001);
    wr(pcs_pkg::ADR_MST_STAT, 16'h0001);
    rdc("timeout clr", pcs_pkg::ADR_MST_STAT, 16'h0000);
    wr(pcs_pkg::ADR_MST_ADRH, 16'h0007);
    acc(1'h0, 16'h0000);
    cmp("cs2 hit", {14'h0, cs_hit}, 16'h0002);
    wr(pcs_pkg::ADR_CS2_BASE, 16'h0000);
    wr(pcs_pkg::ADR_MST_ADRH, 16'h00FF);
    acc(1'h0, 16'h0000);
    cmp("cs1 top", {14'h0, cs_hit}, 16'h0001);
    $display("test master done");
    hst(1'h1, 2'h0, 8'h11);
    rdc("idle flags", pcs_pkg::ADR_STATUS, 16'h008F);
    wr(pcs_pkg::ADR_CONTROL, 16'h0001);
    for (int i = 0; i < 4; i++) hst(1'h1, 2'(i), 8'(8'h10 + i));
    rdc("in full", pcs_pkg::ADR_STATUS, 16'h8F8F);
    rdc("in word", pcs_pkg::ADR_IN_WORD0, 16'h1110);
    rdc("in read", pcs_pkg::ADR_STATUS, 16'h0C8F);
    hst(1'h1, 2'h3, 8'h55);
    rdc("overflow", pcs_pkg::ADR_STATUS, 16'h4C8F);
    wr(pcs_pkg::ADR_STATUS, 16'h0000);
    rdc("ovf clr", pcs_pkg::ADR_STATUS, 16'h0C8F);
    wr(pcs_pkg::ADR_OUT_WORD0, 16'hBEEF);
    rdc("out full", pcs_pkg::ADR_STATUS, 16'h0C0C);
    hst(1'h0, 2'h1, 8'h00);
    cmp("host data", {8'h00, host_d_out}, 16'h00BE);
    rdc("out read", pcs_pkg::ADR_STATUS, 16'h0C8F);
    hst(1'h0, 2'h0, 8'h00);
    rdc("underflow", pcs_pkg::ADR_STATUS, 16'h0CCF);
    $display("test slave done");
    cal_seconds_clk <= 1'h1;
    wr(pcs_pkg::ADR_CONTROL, 16'h0002);
    wr(pcs_pkg::ADR_PAD_CFG, 16'h0002);
    tick;
    tick;
    cmp("cal sec", {14'h0, cal_pin_oe_b, cal_pin_out}, 16'h0001);
    wr(pcs_pkg::ADR_PAD_CFG, 16'h0001);
    rdc("pad", pcs_pkg::ADR_PAD_CFG, 16'h0001);
    cmp("cal alarm", {14'h0, cal_pin_oe_b, cal_pin_out}, 16'h0000);
    cmp("threshold", {15'h0, input_threshold_select}, 16'h0001);
    wr(pcs_pkg::ADR_CONTROL, 16'h0000);
    tick;
    tick;
    cmp("cal off", {15'h0, cal_pin_oe_b}, 16'h0001);
    $display("test calendar done");
    end_of_test;
  end
endmodule : test_parallel_port_cs_timing_status
`default_nettype wire
